// ===== silp_defines.vh
// Purpose: shared constants of the scan image line processor
// Assumes: 8-bit density pixels, 0 is white
// Notes: definitions only
`ifndef SILP_DEFINES_VH
`define SILP_DEFINES_VH

// ----------------------------------------------------------------
// pixel values
// ----------------------------------------------------------------
`define SILP_PIX_WHITE 8'h00
`define SILP_PIX_MAX 8'hFF
`define SILP_GRAD_THRESH 8'h80
`define SILP_GAMMA_TEXT_OFS 12'h040

// ----------------------------------------------------------------
// scaling step: fixed point, unity ratio
// ----------------------------------------------------------------
`define SILP_FRAC_BITS 6
`define SILP_SCALE_ONE 8'h40

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define SILP_ST_FILL 2'h0
`define SILP_ST_FLUSH 2'h1
`define SILP_ST_READ 2'h2

// ----------------------------------------------------------------
// copy modes
// ----------------------------------------------------------------
`define SILP_MODE_TEXT 1'b0
`define SILP_MODE_PHOTO 1'b1

`endif

// ===== silp_line_mem.v
// Purpose: one-line pixel store for the scan image line processor
// Assumes: single clock, one write and one read port
// Notes: read data is registered, valid one cycle after rd_en
`timescale 1ns/100ps

module silp_line_mem #(
  parameter WIDTH = 8,
  parameter AW = 11,
  parameter DEPTH = 2048
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // write and registered read
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // silp_line_mem

// ===== silp_line_proc.v
// Purpose: pixel line pipeline: range, filter, line memory edit, trim/mask,
//          reversal, gamma, gradation and effective area gating
// Assumes: pixels arrive on CORE_CLK; at least one idle cycle after last
// Notes: config ports are sampled before the first pixel of each line
`timescale 1ns/100ps
`include "silp_defines.vh"

module silp_line_proc #(
  parameter AW = 11,
  parameter DEPTH = 2048,
  parameter LW = 12
) (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] PIX_IN,
  input wire PIX_IN_VALID,
  input wire PIX_IN_LAST,
  output wire IN_READY,
  input wire PAGE_START,
  input wire [7:0] BG_LEVEL,
  input wire LPF_EN,
  input wire EDGE_EN,
  input wire [7:0] SCALE_STEP,
  input wire MIRROR_EN,
  input wire TRIM_EN,
  input wire MASK_EN,
  input wire [AW-1:0] RECT_X0,
  input wire [AW-1:0] RECT_X1,
  input wire [LW-1:0] RECT_Y0,
  input wire [LW-1:0] RECT_Y1,
  input wire NEG_EN,
  input wire COPY_MODE,
  input wire [AW-1:0] AREA_X0,
  input wire [AW-1:0] AREA_X1,
  input wire [LW-1:0] AREA_Y0,
  input wire [LW-1:0] AREA_Y1,
  output reg [7:0] PIX_OUT,
  output reg PIX_OUT_VALID,
  output reg PIX_OUT_LAST,
  output reg [LW-1:0] LINE_COUNT
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // saturate a signed value to a pixel
  function [7:0] sat8;
    input signed [11:0] v;
    begin
      if (v < 0) sat8 = `SILP_PIX_WHITE;
      else if (v > 12'sd255) sat8 = `SILP_PIX_MAX;
      else sat8 = v[7:0];
    end
  endfunction
  // 3x1 window: average or edge enhancement
  function [7:0] filt;
    input [7:0] a, x, b;
    input lpf, sharp;
    reg [9:0] sum;
    reg [9:0] avg;
    reg signed [11:0] hp;
    begin
      sum = {2'b00, a} + {2'b00, x} + {2'b00, b};
      avg = sum / 10'd3;
      hp = $signed({3'b000, x, 1'b0}) - $signed({4'h0, a}) - $signed({4'h0, b});
      if (sharp) filt = sat8($signed({4'h0, x}) + (hp >>> 1));
      else if (lpf) filt = avg[7:0];
      else filt = x;
    end
  endfunction
  // inclusive rectangle test
  function in_rect;
    input [15:0] x, y, x0, x1, y0, y1;
    begin
      in_rect = (x >= x0) && (x <= x1) && (y >= y0) && (y <= y1);
    end
  endfunction
  // gamma curve per copy mode
  function [7:0] gamma;
    input [7:0] x;
    input mode;
    reg [15:0] bow;
    begin
      bow = {8'h00, x} * {8'h00, ~x};
      if (mode == `SILP_MODE_TEXT) begin
        gamma = sat8($signed({3'b000, x, 1'b0}) - $signed(`SILP_GAMMA_TEXT_OFS));
      end else begin
        gamma = sat8($signed({4'h0, x}) + $signed({5'h00, bow[15:9]}));
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // per-line settings
  // ----------------------------------------------------------------
  reg [1:0] state;
  reg have_cur;
  wire [7:0] c_bg;
  wire c_lpf, c_edge, c_mir, c_trim, c_mask, c_neg, c_mode;
  wire [7:0] c_step;
  wire [AW-1:0] c_rx0, c_rx1, c_ax0, c_ax1;
  wire [LW-1:0] c_ry0, c_ry1, c_ay0, c_ay1;
  reg [AW+`SILP_FRAC_BITS:0] acc;
  reg [AW:0] len;
  wire [AW+`SILP_FRAC_BITS:0] acc_nx = acc + {{(AW+`SILP_FRAC_BITS-7){1'b0}}, c_step};
  wire [AW:0] src = acc[AW+`SILP_FRAC_BITS:`SILP_FRAC_BITS];
  wire [AW:0] src_nx = acc_nx[AW+`SILP_FRAC_BITS:`SILP_FRAC_BITS];
  wire rd_go = (state == `SILP_ST_READ) && (src < len);
  wire cfg_load = ((state == `SILP_ST_FILL) && !have_cur && !PIX_IN_VALID) ||
                  ((state == `SILP_ST_READ) && !rd_go);
  // settings word: one latch for all fields, split back into named fields
  localparam CW = 23 + 4 * AW + 4 * LW;
  localparam [CW-1:0] CFG_RST = {8'h00, 6'h00, `SILP_MODE_TEXT, `SILP_SCALE_ONE,
                                 {(3*AW){1'b0}}, {AW{1'b1}}, {(3*LW){1'b0}}, {LW{1'b1}}};
  wire [CW-1:0] next_cfg = {BG_LEVEL, LPF_EN, EDGE_EN, MIRROR_EN, TRIM_EN, MASK_EN, NEG_EN,
                            COPY_MODE, ((SCALE_STEP == 8'h00) ? `SILP_SCALE_ONE : SCALE_STEP),
                            RECT_X0, RECT_X1, AREA_X0, AREA_X1, RECT_Y0, RECT_Y1, AREA_Y0, AREA_Y1};
  reg [CW-1:0] cfg;
  assign {c_bg, c_lpf, c_edge, c_mir, c_trim, c_mask, c_neg, c_mode, c_step,
          c_rx0, c_rx1, c_ax0, c_ax1, c_ry0, c_ry1, c_ay0, c_ay1} = cfg;
  // sample all settings only between lines
  always @(posedge CORE_CLK) begin
    if (RST) begin
      cfg <= CFG_RST;
    end else if (cfg_load) begin
      cfg <= next_cfg;
    end
  end
  // ----------------------------------------------------------------
  // input side: range correction and 3x1 window
  // ----------------------------------------------------------------
  reg [7:0] cur, prv;
  reg cur_first;
  reg [AW-1:0] wcnt;
  wire [7:0] bgv = (PIX_IN > c_bg) ? (PIX_IN - c_bg) : `SILP_PIX_WHITE;
  wire [7:0] a_eff = cur_first ? cur : prv;
  reg wr_en;
  reg [7:0] wr_data;
  // window write strobe: a pixel is final once its follower is known
  always @* begin
    wr_en = 1'b0;
    wr_data = cur;
    if ((state == `SILP_ST_FILL) && PIX_IN_VALID && have_cur) begin
      wr_en = 1'b1;
      wr_data = filt(a_eff, cur, bgv, c_lpf, c_edge);
    end else if (state == `SILP_ST_FLUSH) begin
      wr_en = 1'b1;
      wr_data = filt(a_eff, cur, cur, c_lpf, c_edge);
    end
  end
  // pixels are accepted only while filling
  assign IN_READY = (state == `SILP_ST_FILL);
  // ----------------------------------------------------------------
  // sequencer: fill, flush, read out
  // ----------------------------------------------------------------
  reg [AW-1:0] ox;
  wire [AW:0] m_addr = len - 1'b1 - src;
  wire [AW-1:0] rd_addr = c_mir ? m_addr[AW-1:0] : src[AW-1:0];
  // state, write counter, read step and line number
  always @(posedge CORE_CLK) begin
    if (RST) begin
      state <= `SILP_ST_FILL;
      have_cur <= 1'b0;
      cur_first <= 1'b0;
      cur <= 8'h00;
      prv <= 8'h00;
      wcnt <= {AW{1'b0}};
      len <= {(AW+1){1'b0}};
      acc <= {(AW+`SILP_FRAC_BITS+1){1'b0}};
      ox <= {AW{1'b0}};
      LINE_COUNT <= {LW{1'b0}};
    end else begin
      if (PAGE_START) LINE_COUNT <= {LW{1'b0}};
      case (state)
        `SILP_ST_FILL: begin
          if (PIX_IN_VALID) begin
            if (have_cur) begin
              wcnt <= wcnt + 1'b1;
              prv <= cur;
            end
            cur_first <= !have_cur;
            cur <= bgv;
            have_cur <= 1'b1;
            if (PIX_IN_LAST) state <= `SILP_ST_FLUSH;
          end
        end
        `SILP_ST_FLUSH: begin
          len <= {1'b0, wcnt} + 1'b1;
          have_cur <= 1'b0;
          acc <= {(AW+`SILP_FRAC_BITS+1){1'b0}};
          ox <= {AW{1'b0}};
          state <= `SILP_ST_READ;
        end
        `SILP_ST_READ: begin
          if (rd_go) begin
            acc <= acc_nx;
            ox <= ox + 1'b1;
          end else begin
            wcnt <= {AW{1'b0}};
            state <= `SILP_ST_FILL;
            if (!PAGE_START) LINE_COUNT <= LINE_COUNT + 1'b1;
          end
        end
        default: state <= `SILP_ST_FILL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line memory
  // ----------------------------------------------------------------
  wire [7:0] rd_data;

  silp_line_mem #(
    .WIDTH(8),
    .AW(AW),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(CORE_CLK),
    .wr_en(wr_en),
    .wr_addr(wcnt),
    .wr_data(wr_data),
    .rd_en(rd_go),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // output side: editing, gamma, gradation, area
  // ----------------------------------------------------------------
  reg rd_vld, rd_last;
  reg [AW-1:0] rd_x;
  reg [7:0] v_edit, v_gam, v_out;
  reg in_r, in_a;

  // companion of the memory read
  always @(posedge CORE_CLK) begin
    if (RST) begin
      rd_vld <= 1'b0;
      rd_last <= 1'b0;
      rd_x <= {AW{1'b0}};
    end else begin
      rd_vld <= rd_go;
      rd_last <= rd_go && (src_nx >= len);
      rd_x <= ox;
    end
  end

  // processing chain on the read pixel
  always @* begin
    in_r = in_rect({{(16-AW){1'b0}}, rd_x}, {{(16-LW){1'b0}}, LINE_COUNT},
                   {{(16-AW){1'b0}}, c_rx0}, {{(16-AW){1'b0}}, c_rx1},
                   {{(16-LW){1'b0}}, c_ry0}, {{(16-LW){1'b0}}, c_ry1});
    in_a = in_rect({{(16-AW){1'b0}}, rd_x}, {{(16-LW){1'b0}}, LINE_COUNT},
                   {{(16-AW){1'b0}}, c_ax0}, {{(16-AW){1'b0}}, c_ax1},
                   {{(16-LW){1'b0}}, c_ay0}, {{(16-LW){1'b0}}, c_ay1});
    v_edit = rd_data;
    if (c_trim && !in_r) v_edit = `SILP_PIX_WHITE;
    if (c_mask && in_r) v_edit = `SILP_PIX_WHITE;
    if (c_neg) v_edit = ~v_edit;
    v_gam = gamma(v_edit, c_mode);
    if (c_mode == `SILP_MODE_TEXT) begin
      v_out = (v_gam >= `SILP_GRAD_THRESH) ? `SILP_PIX_MAX : `SILP_PIX_WHITE;
    end else begin
      v_out = v_gam;
    end
    if (!in_a) v_out = `SILP_PIX_WHITE;
  end

  // registered output stream
  always @(posedge CORE_CLK) begin
    if (RST) begin
      PIX_OUT <= 8'h00;
      PIX_OUT_VALID <= 1'b0;
      PIX_OUT_LAST <= 1'b0;
    end else begin
      PIX_OUT_VALID <= rd_vld;
      PIX_OUT_LAST <= rd_vld && rd_last;
      PIX_OUT <= rd_vld ? v_out : 8'h00;
    end
  end

endmodule // silp_line_proc

// ===== silp_line_chk_asserts.sv
// Purpose: port checks on the line processor stream timing
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every silp_line_proc instance
`timescale 1ns/100ps

module silp_line_chk #(
  parameter LW = 12
) (
  input wire CORE_CLK,
  input wire RST,
  input wire PIX_IN_VALID,
  input wire PIX_IN_LAST,
  input wire IN_READY,
  input wire PAGE_START,
  input wire [7:0] PIX_OUT,
  input wire PIX_OUT_VALID,
  input wire PIX_OUT_LAST,
  input wire [LW-1:0] LINE_COUNT
);
  // ------------------------------------------------------------
  // stream timing checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // last pixel of a line accepted
  wire took_last = IN_READY && PIX_IN_VALID && PIX_IN_LAST;
  a_idle_white: assert property (!PIX_OUT_VALID |-> PIX_OUT == 8'h00)
    else $error("output pixel not white while idle");
  a_ready_drop: assert property (took_last |=> !IN_READY ##1 !IN_READY)
    else $error("input not held off after line end");
  a_first_out: assert property (took_last |-> !PIX_OUT_VALID [*4] ##1 PIX_OUT_VALID)
    else $error("read-out start late or early");
  a_last_valid: assert property (PIX_OUT_LAST |-> PIX_OUT_VALID)
    else $error("line end flag without pixel");
  a_no_gap: assert property (PIX_OUT_VALID && !PIX_OUT_LAST |=> PIX_OUT_VALID)
    else $error("gap inside output line");
  a_page_clear: assert property (PAGE_START |=> LINE_COUNT == 0)
    else $error("line count not cleared by page start");
  a_line_step: assert property (PIX_OUT_LAST |-> LINE_COUNT == $past(LINE_COUNT, 3) + 1'b1)
    else $error("line count did not step once per line");
  a_reset_idle: assert property ($fell(RST) |-> IN_READY && !PIX_OUT_VALID && LINE_COUNT == 0)
    else $error("not idle after reset");
  c_line_in: cover property (took_last);
  c_line_out: cover property (PIX_OUT_LAST);
  c_page: cover property (PAGE_START);
endmodule // silp_line_chk

bind silp_line_proc silp_line_chk #(.LW(LW)) chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .PIX_IN_VALID(PIX_IN_VALID), .PIX_IN_LAST(PIX_IN_LAST),
  .IN_READY(IN_READY), .PAGE_START(PAGE_START), .PIX_OUT(PIX_OUT),
  .PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT_LAST(PIX_OUT_LAST), .LINE_COUNT(LINE_COUNT)
);

// ===== silp_line_sink.sv
// Purpose: writing path model, collects one output line
// Assumes: no back-pressure, every valid pixel is taken
// Notes: index restarts after each line end flag
`timescale 1ns/100ps

module silp_line_sink (
  input wire clk,
  input wire [7:0] pix,
  input wire vld,
  input wire lst,
  output reg [11:0] cnt
);
  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  reg [7:0] got [0:15];
  reg fresh = 1'b1;
  initial cnt = 12'h000;
  // store pixels of the current line in order
  always @(posedge clk) begin
    if (vld) begin
      got[fresh ? 12'h000 : cnt] <= pix;
      cnt <= fresh ? 12'h001 : cnt + 12'h001;
      fresh <= lst;
    end
  end
endmodule // silp_line_sink

// ===== silp_line_proc_bench.sv
// Purpose: line-by-line tests of the pixel pipeline
// Assumes: 100 MHz clock, config set in idle cycles except the mid-line NEG_EN toggle of one test
// Notes: expectations from a small reference of the chain
`timescale 1ns/100ps

module silp_line_proc_bench;
  reg clk = 0, rst = 1, v = 0, l = 0, ps = 0, lpf = 0, edg = 0, mir = 0;
  reg trm = 0, msk = 0, neg = 0, mode = 1, nx = 0;
  reg [7:0] pix = 0, bg = 0, step = 8'h40;
  reg [10:0] rx0 = 0, rx1 = 0, ax0 = 0, ax1 = 11'h7ff;
  reg [11:0] ry0 = 0, ry1 = 12'hfff, ay0 = 0, ay1 = 12'hfff;
  wire rdy, ov, ol;
  wire [7:0] op;
  wire [11:0] lc, cnt;
  integer mismatches = 0, samples_checked = 0, y = 0, n = 0;
  reg [7:0] src [0:3];
  // ------------------------------------------------------------
  // clock, design and sink
  // ------------------------------------------------------------
  initial forever #5 clk = ~clk;
  silp_line_proc uut (
    .CORE_CLK(clk), .RST(rst), .PIX_IN(pix), .PIX_IN_VALID(v), .PIX_IN_LAST(l),
    .IN_READY(rdy), .PAGE_START(ps), .BG_LEVEL(bg), .LPF_EN(lpf), .EDGE_EN(edg),
    .SCALE_STEP(step), .MIRROR_EN(mir), .TRIM_EN(trm), .MASK_EN(msk), .RECT_X0(rx0),
    .RECT_X1(rx1), .RECT_Y0(ry0), .RECT_Y1(ry1), .NEG_EN(neg), .COPY_MODE(mode),
    .AREA_X0(ax0), .AREA_X1(ax1), .AREA_Y0(ay0), .AREA_Y1(ay1), .PIX_OUT(op),
    .PIX_OUT_VALID(ov), .PIX_OUT_LAST(ol), .LINE_COUNT(lc)
  );
  silp_line_sink snk (.clk(clk), .pix(op), .vld(ov), .lst(ol), .cnt(cnt));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task close_out;
    begin
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task cmp(input [47:0] nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (e !== g) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // background removed source pixel, ends reuse nearest
  function automatic integer sub(input integer k);
    integer p;
    begin
      p = src[k < 0 ? 0 : (k >= n ? n - 1 : k)];
      sub = (p <= bg) ? 0 : p - bg;
    end
  endfunction
  // reference for output pixel i of line y
  function automatic integer ex(input integer i);
    integer k, a, x, b, t;
    begin
      k = (i * step) >> 6;
      if (mir) k = n - 1 - k;
      a = sub(k - 1);
      x = sub(k);
      b = sub(k + 1);
      if (edg) begin
        t = x + ((2 * x - a - b) >>> 1);
        x = t < 0 ? 0 : (t > 255 ? 255 : t);
      end else if (lpf) x = (a + x + b) / 3;
      t = (i >= rx0 && i <= rx1 && y >= ry0 && y <= ry1);
      if ((trm && !t) || (msk && t)) x = 0;
      if (nx) x = 255 - x;
      if (mode) x = x + ((x * (255 - x)) >> 9);
      else x = (2 * x - 64 >= 128) ? 255 : 0;
      if (i < ax0 || i > ax1 || y < ay0 || y > ay1) x = 0;
      ex = x;
    end
  endfunction
  // send one line back to back, collect and compare
  task line(input integer len, input integer tog);
    integer i, j, e;
    begin
      n = len;
      repeat (2) @(posedge clk);
      nx = neg;
      for (i = 0; i < len; i = i + 1) begin
        pix <= src[i];
        v <= 1;
        l <= (i == len - 1);
        if (i == 1 && tog) neg <= ~neg;
        @(posedge clk);
      end
      v <= 0;
      l <= 0;
      for (j = 0; j < 200; j = j + 1) begin
        @(posedge clk);
        #1;
        if (ol === 1'b1) break;
      end
      if (j == 200) begin
        mismatches = mismatches + 1;
        close_out;
      end
      @(posedge clk);
      #1;
      e = (len * 64 + step - 1) / step;
      cmp("count", e[15:0], {4'h0, cnt});
      for (i = 0; i < e; i = i + 1) cmp("pixel", ex(i), {8'h00, snk.got[i]});
      cmp("lines", y[15:0] + 16'h0001, {4'h0, lc});
      cmp("ready", 16'h0001, {15'h0000, rdy});
      y = y + 1;
      @(posedge clk);
      if (tog) neg <= ~neg;
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    src[0] = 8'h10;
    src[1] = 8'h80;
    src[2] = 8'hc0;
    src[3] = 8'hff;
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    ps <= 1;
    @(posedge clk);
    ps <= 0;
    line(4, 0);
    bg <= 8'h20;
    line(4, 0);
    bg <= 0;
    lpf <= 1;
    line(4, 0);
    edg <= 1;
    line(4, 0);
    lpf <= 0;
    edg <= 0;
    step <= 8'h20;
    line(3, 0);
    step <= 8'h80;
    line(4, 0);
    step <= 8'h40;
    mir <= 1;
    line(4, 0);
    mir <= 0;
    rx0 <= 1;
    rx1 <= 2;
    trm <= 1;
    line(4, 0);
    trm <= 0;
    msk <= 1;
    line(4, 0);
    msk <= 0;
    neg <= 1;
    line(4, 0);
    neg <= 0;
    line(4, 1);
    mode <= 0;
    line(4, 0);
    mode <= 1;
    ax0 <= 1;
    ax1 <= 2;
    ay0 <= y[11:0] + 12'h001;
    line(4, 0);
    line(4, 0);
    line(1, 0);
    close_out;
  end
endmodule // silp_line_proc_bench
